// ===== core/ldcf_core.sv
`timescale 1ns/100ps
`default_nettype none
module ldcf_core
    import ldcf_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // serial link pins
    input  wire logic i_shift_clock,
    input  wire logic i_latch_strobe,
    input  wire logic i_serial_in,
    input  wire logic i_grayscale_clock,
    output logic      o_serial_out,
    // led side
    output logic [15:0] o_current_sink_outputs,
    output logic [4:0]  o_scan_line,
    // gain and flow
    output logic        o_high_band_select,
    output logic [4:0]  o_gain_mantissa,
    output logic [9:0]  o_gain_x256,
    output logic        o_data_ready
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]   shift_clock_s;
        logic [2:0]   le_s;
        logic [2:0]   sdi_s;
        logic [2:0]   grayscale_clock_s;
        logic [15:0]  in_sr;
        logic [15:0]  out_sr;
        logic [15:0]  cfg1;
        logic [15:0]  cfg2;
        logic [3:0]   edges;
        logic         pre_armed;
        ldcf_pwm_type st;
        logic [8:0]   pos;
        logic [4:0]   line;
        logic [4:0]   sect;
        logic [3:0]   wr_ch;
        logic [4:0]   wr_line;
        logic [2:0]   dim_cnt;
        logic [15:0]  sink;
        logic [9:0]   gain;
    } ldcf_state_type;

    localparam ldcf_state_type S_RST = '{
        cfg1:    CFG1_RST,
        cfg2:    CFG2_RST,
        st:      PWM_STOP,
        default: '0
    };

    ldcf_state_type s_q, s_d;
    logic [15:0] gmem [512];

    logic        shift_clock_rise;
    logic        grayscale_clock_rise;
    logic        le_fall;
    logic        wr1_go;
    logic        wr2_go;
    logic        rd1_go;
    logic        rd2_go;
    logic        vsync_go;
    logic        srst_go;
    logic        pre_go;
    logic        latch_go;
    logic        gray14;
    logic        fifo_vld;
    logic        drain;
    logic [15:0] fifo_dat;
    logic [4:0]  sect_max;
    logic [4:0]  scan_max;
    logic [8:0]  step;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [9:0] gain_of(
        input logic       band,
        input logic [4:0] d
    );
        int t;
        if (band) begin
            t = (GAIN_MUL * int'(d) + GAIN_HI_OFF) * GAIN_ONE
                / GAIN_HI_DEN;
        end else begin
            t = GAIN_MUL * int'(d) + GAIN_LO_OFF;
        end
        return 10'(t);
    endfunction

    // round up: a partial cycle still blanks
    function automatic logic [2:0] dim_cycles(input logic [2:0] c);
        int ns;
        ns = int'(c) * DIM_STEP_NS;
        return 3'((ns + CLK_NS - 1) / CLK_NS);
    endfunction

    // ****************************************
    // pin edges and command decode
    // ****************************************
    assign shift_clock_rise = s_q.shift_clock_s[1] & ~s_q.shift_clock_s[2];
    assign grayscale_clock_rise = s_q.grayscale_clock_s[1] & ~s_q.grayscale_clock_s[2];
    assign le_fall   = s_q.le_s[2] & ~s_q.le_s[1];

    assign wr1_go   = le_fall & (s_q.edges == CMD_WR1) & s_q.pre_armed;
    assign wr2_go   = le_fall & (s_q.edges == CMD_WR2) & s_q.pre_armed;
    assign rd1_go   = le_fall & (s_q.edges == CMD_RD1);
    assign rd2_go   = le_fall & (s_q.edges == CMD_RD2);
    assign vsync_go = le_fall & (s_q.edges == CMD_VSYNC);
    assign srst_go  = le_fall & (s_q.edges == CMD_SRST);
    assign pre_go   = le_fall & (s_q.edges == CMD_PRE);
    assign latch_go = le_fall & (s_q.edges == CMD_LATCH);

    assign gray14   = ~s_q.cfg1[GRAY_BIT];
    assign sect_max = gray14 ? SECT14_MAX : SECT13_MAX;
    assign scan_max = s_q.cfg1[SCAN_HI:SCAN_LO];
    // multiplier and double refresh speed the slot
    assign step = 9'h001 << {s_q.cfg1[MULT_BIT] & s_q.cfg2[DBL_BIT],
                             s_q.cfg1[MULT_BIT] ^ s_q.cfg2[DBL_BIT]};

    // memory is written only between slots to keep a slot stable
    assign drain = fifo_vld & ((s_q.st != PWM_RUN) | (s_q.pos == '0));

    // ****************************************
    // data path buffer
    // ****************************************
    ldcf_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_reset     (i_reset),
        .i_in_valid  (latch_go),
        .o_in_ready  (o_data_ready),
        .i_in_data   (s_q.in_sr),
        .o_out_valid (fifo_vld),
        .i_out_ready (drain),
        .o_out_data  (fifo_dat)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [9:0]  sum;
        logic [15:0] w;
        logic [9:0]  lim;
        sum = '0;
        w   = '0;
        lim = '0;
        s_d = s_q;
        s_d.shift_clock_s = {s_q.shift_clock_s[1:0], i_shift_clock};
        s_d.le_s   = {s_q.le_s[1:0], i_latch_strobe};
        s_d.sdi_s  = {s_q.sdi_s[1:0], i_serial_in};
        s_d.grayscale_clock_s = {s_q.grayscale_clock_s[1:0], i_grayscale_clock};

        if (shift_clock_rise) begin
            s_d.in_sr  = {s_q.in_sr[14:0], s_q.sdi_s[1]};
            s_d.out_sr = {s_q.out_sr[14:0], s_q.sdi_s[1]};
            if (s_q.le_s[1] && s_q.edges != EDGE_MAX) begin
                s_d.edges = s_q.edges + 1'b1;
            end
        end
        if (le_fall) begin
            s_d.edges = '0;
        end

        if (wr1_go) begin
            s_d.cfg1 = s_q.in_sr;
        end
        if (wr2_go) begin
            s_d.cfg2 = s_q.in_sr;
        end
        if (wr1_go || wr2_go) begin
            s_d.pre_armed = 1'b0;
        end
        if (pre_go) begin
            s_d.pre_armed = 1'b1;
        end
        if (rd1_go) begin
            s_d.out_sr = s_q.cfg1;
        end
        if (rd2_go) begin
            s_d.out_sr = s_q.cfg2;
        end

        // fill line by line, sixteen channels each
        if (drain) begin
            s_d.wr_ch = s_q.wr_ch + 1'b1;
            if (s_q.wr_ch == 4'hF) begin
                s_d.wr_line = (s_q.wr_line >= scan_max) ? '0
                            : s_q.wr_line + 1'b1;
            end
        end

        if (s_q.dim_cnt != '0) begin
            s_d.dim_cnt = s_q.dim_cnt - 1'b1;
        end

        case (s_q.st)
            PWM_STOP: begin
                s_d.pos  = '0;
                s_d.line = '0;
                s_d.sect = '0;
            end
            PWM_RUN: begin
                // a shrunk scan count takes effect at once
                if (s_q.line > scan_max) begin
                    s_d.line = '0;
                end
                if (grayscale_clock_rise) begin
                    sum = {1'b0, s_q.pos} + {1'b0, step};
                    s_d.pos = sum[8:0];
                    if (sum[9]) begin
                        if (s_q.line >= scan_max) begin
                            s_d.line = '0;
                            s_d.sect = (s_q.sect >= sect_max) ? '0
                                     : s_q.sect + 1'b1;
                        end else begin
                            s_d.line = s_q.line + 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_d.st = PWM_STOP;
            end
        endcase

        if (vsync_go || srst_go) begin
            s_d.st      = vsync_go ? PWM_RUN : PWM_STOP;
            s_d.pos     = '0;
            s_d.line    = '0;
            s_d.sect    = '0;
            s_d.wr_ch   = '0;
            s_d.wr_line = '0;
        end
        // blank the start of a slot whenever the scan line changes
        if (s_d.line != s_q.line) begin
            s_d.dim_cnt = dim_cycles(s_q.cfg2[DIM_HI:DIM_LO]);
        end

        // base per section plus remainder spread over sections
        for (int ch = 0; ch < 16; ch++) begin
            w   = gmem[{s_q.line, 4'(ch)}];
            lim = {1'b0, w[15:7]};
            if (gray14) begin
                if (s_q.sect < w[6:2]) begin
                    lim = lim + 10'h001;
                end
            end else if (s_q.sect < {1'b0, w[6:3]}) begin
                lim = lim + 10'h001;
            end
            s_d.sink[ch] = (s_q.st == PWM_RUN) && (s_q.dim_cnt == '0)
                         && ({1'b0, s_q.pos} < lim);
        end

        s_d.gain = gain_of(s_q.cfg1[BAND_BIT], s_q.cfg1[MANT_HI:0]);
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (drain) begin
            gmem[{s_q.wr_line, s_q.wr_ch}] <= fifo_dat;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_serial_out           = s_q.out_sr[15];
    assign o_current_sink_outputs = s_q.sink;
    assign o_scan_line            = s_q.line;
    assign o_high_band_select     = s_q.cfg1[BAND_BIT];
    assign o_gain_mantissa        = s_q.cfg1[MANT_HI:0];
    assign o_gain_x256            = s_q.gain;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    cfg_guard_a: assert property (
        $changed(s_q.cfg1) |-> $past(wr1_go))
        else $error("register one changed without armed write");
    cfg_capture_a: assert property (
        wr2_go |=> s_q.cfg2 == $past(s_q.in_sr))
        else $error("register two did not take shifted word");
    read_msb_a: assert property (
        rd1_go |=> o_serial_out == $past(s_q.cfg1[15]))
        else $error("read did not present msb");
    scan_bound_a: assert property (
        (s_q.st == PWM_RUN && s_q.line > scan_max) |=>
        s_q.line == 5'h00)
        else $error("scan line beyond configured count");
    sect_bound_a: assert property (
        (s_q.st == PWM_RUN && s_q.cfg1[GRAY_BIT] && grayscale_clock_rise
         && s_q.line >= scan_max && s_q.pos >= 9'h1FF) |=>
        s_q.sect <= 5'h0F)
        else $error("13-bit mode left sixteen sections");
    mult_step_a: assert property (
        (grayscale_clock_rise && s_q.st == PWM_RUN && s_q.cfg1[MULT_BIT]
         && !s_q.cfg2[DBL_BIT] && !vsync_go && !srst_go) |=>
        s_q.pos == $past(s_q.pos) + 9'h002)
        else $error("multiplier step is not two");
    dim_blank_a: assert property (
        ($changed(s_q.line) && s_q.cfg2[DIM_HI:DIM_LO] != 3'h0) |=>
        o_current_sink_outputs == 16'h0000)
        else $error("dim compensation did not blank");

    stop_dark_a: assert property (
        (s_q.st != PWM_RUN) [*2] |-> o_current_sink_outputs == 16'h0000)
        else $error("sinks on while stopped");

    unity_gain_a: assert property (
        (s_q.cfg1[5:0] == 6'h2B) [*2] |-> o_gain_x256 == 10'h103)
        else $error("reset gain is not unity");

    cover_write_c: cover property (wr1_go ##[1:300] rd1_go);
    cover_pre_c: cover property (pre_go);
    cover_full_c: cover property (!o_data_ready);
    cover_wrap_c: cover property ($fell(s_q.sect != '0));

endmodule
`default_nettype wire

// ===== core/ldcf_pkg.sv
package ldcf_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_NS      = 50;
    localparam int DIM_STEP_NS = 5;

    // ********************************
    // register reset values
    // ********************************
    localparam logic [15:0] CFG1_RST = 16'h032B;
    localparam logic [15:0] CFG2_RST = 16'h1010;

    // ********************************
    // field positions
    // ********************************
    localparam int SCAN_HI  = 12;
    localparam int SCAN_LO  = 8;
    localparam int GRAY_BIT = 7;
    localparam int MULT_BIT = 6;
    localparam int BAND_BIT = 5;
    localparam int MANT_HI  = 4;
    localparam int DBL_BIT  = 10;
    localparam int DIM_HI   = 3;
    localparam int DIM_LO   = 1;

    // ********************************
    // commands: shift edges under strobe
    // ********************************
    localparam logic [3:0] CMD_LATCH = 4'h1;
    localparam logic [3:0] CMD_VSYNC = 4'h2;
    localparam logic [3:0] CMD_WR1   = 4'h4;
    localparam logic [3:0] CMD_RD1   = 4'h5;
    localparam logic [3:0] CMD_WR2   = 4'h8;
    localparam logic [3:0] CMD_RD2   = 4'h9;
    localparam logic [3:0] CMD_SRST  = 4'hA;
    localparam logic [3:0] CMD_PRE   = 4'hE;
    localparam logic [3:0] EDGE_MAX  = 4'hF;

    // ********************************
    // pwm and gain
    // ********************************
    localparam logic [4:0] SECT14_MAX = 5'h1F;
    localparam logic [4:0] SECT13_MAX = 5'h0F;
    localparam int GAIN_MUL    = 3;
    localparam int GAIN_HI_OFF = 33;
    localparam int GAIN_HI_DEN = 65;
    localparam int GAIN_LO_OFF = 32;
    localparam int GAIN_ONE    = 256;

    typedef enum logic [1:0] {
        PWM_STOP = 2'b00,
        PWM_RUN  = 2'b01
    } ldcf_pwm_type;

endpackage

// ===== core/ldcf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ldcf_fifo
    import ldcf_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)(
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } ldcf_fifo_type;

    ldcf_fifo_type f_q, f_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign o_in_ready  = (f_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (f_q.cnt != '0);
    assign o_out_data  = mem[f_q.rd];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.wr = (f_q.wr == AW'(DEPTH-1)) ? '0 : f_q.wr + 1'b1;
        end
        if (pop) begin
            f_d.rd = (f_q.rd == AW'(DEPTH-1)) ? '0 : f_q.rd + 1'b1;
        end
        if (push && !pop) begin
            f_d.cnt = f_q.cnt + 1'b1;
        end else if (pop && !push) begin
            f_d.cnt = f_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[f_q.wr] <= i_in_data;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/ldcf_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ldcf_ctrl_model
    import ldcf_pkg::*;
(
    // clock
    input  wire logic i_sys_clk,
    // pins toward the driver
    output logic      o_shift_clock,
    output logic      o_latch_strobe,
    output logic      o_serial_in,
    output logic      o_grayscale_clock,
    input  wire logic i_serial_out
);
    // pins must sit still at least three clocks, four gives margin
    localparam int HOLD = 4;

    initial begin
        o_shift_clock     = 1'b0;
        o_latch_strobe    = 1'b0;
        o_serial_in       = 1'b0;
        o_grayscale_clock = 1'b0;
    end

    // ****************************************
    // pin wiggling
    // ****************************************
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    task automatic rise();
        o_shift_clock = 1'b1;
        idle(HOLD);
        o_shift_clock = 1'b0;
        idle(HOLD);
    endtask

    // pwm clock pulses, slow enough for the pin synchroniser
    task automatic gray(input int n);
        repeat (n) begin
            o_grayscale_clock = 1'b1;
            idle(HOLD);
            o_grayscale_clock = 1'b0;
            idle(HOLD);
        end
    endtask

    task automatic send(input logic [15:0] word, input logic [3:0] edges);
        for (int i = 15; i >= 0; i--) begin
            o_serial_in = word[i];
            if (i == int'(edges) - 1) begin
                o_latch_strobe = 1'b1;
            end
            idle(HOLD);
            rise();
        end
        o_latch_strobe = 1'b0;
        // data no longer valid: show a changed level, not the last bit
        o_serial_in = ~o_serial_in;
        idle(2 * HOLD);
    endtask

    task automatic write_reg(input logic [3:0] cmd, input logic [15:0] word);
        send(16'h0000, CMD_PRE);
        send(word, cmd);
    endtask

    task automatic read_reg(input logic [3:0] cmd, output logic [15:0] val);
        send(16'h0000, cmd);
        val[15] = i_serial_out;
        for (int i = 14; i >= 0; i--) begin
            rise();
            val[i] = i_serial_out;
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench/led_driver_config_fields_tb.sv
`timescale 1ns/100ps
`default_nettype none
module led_driver_config_fields_tb
    import ldcf_pkg::*;
;
    logic        sys_clk;
    logic        reset;
    logic        shift_clock;
    logic        latch_strobe;
    logic        serial_in;
    logic        grayscale_clock;
    logic        serial_out;
    logic [15:0] sinks;
    logic [4:0]  scan_line;
    logic        high_band;
    logic [4:0]  mantissa;
    logic [9:0]  gain_x256;
    logic        data_ready;
    logic [15:0] rd;
    logic [15:0] pix;
    int          n_errors;
    int          check_count;
    logic [15:0] words [5];

    ldcf_core #(.FIFO_DEPTH(8)) dut (
        .i_sys_clk              (sys_clk),
        .i_reset                (reset),
        .i_shift_clock          (shift_clock),
        .i_latch_strobe         (latch_strobe),
        .i_serial_in            (serial_in),
        .i_grayscale_clock      (grayscale_clock),
        .o_serial_out           (serial_out),
        .o_current_sink_outputs (sinks),
        .o_scan_line            (scan_line),
        .o_high_band_select     (high_band),
        .o_gain_mantissa        (mantissa),
        .o_gain_x256            (gain_x256),
        .o_data_ready           (data_ready)
    );

    ldcf_ctrl_model partner (
        .i_sys_clk         (sys_clk),
        .o_shift_clock     (shift_clock),
        .o_latch_strobe    (latch_strobe),
        .o_serial_in       (serial_in),
        .o_grayscale_clock (grayscale_clock),
        .i_serial_out      (serial_out)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // gain in 1/256 units, truncated
    function automatic logic [15:0] gain_ref(input logic [5:0] g);
        int d = int'(g[4:0]);
        if (g[5]) begin
            return 16'((256 * (3 * d + 33)) / 65);
        end
        return 16'(3 * d + 32);
    endfunction

    task automatic check_gain(input logic [15:0] cfg);
        check("band", {15'h0000, high_band}, {15'h0000, cfg[5]});
        check("mantissa", {11'h000, mantissa}, {11'h000, cfg[4:0]});
        check("gain", {6'h00, gain_x256}, gain_ref(cfg[5:0]));
    endtask

    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        n_errors    = 0;
        check_count = 0;
        reset       = 1'b1;
        words       = '{16'h1fff, 16'h0000, 16'h001f, 16'h0730, 16'h00e0};
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_gain(16'h032b);
        check("ready", {15'h0000, data_ready}, 16'h0001);
        partner.read_reg(CMD_RD1, rd);
        check("cfg1 reset", rd, 16'h032b);
        partner.read_reg(CMD_RD2, rd);
        check("cfg2 reset", rd, 16'h1010);
        // unarmed write must leave the register alone
        partner.send(16'h0730, CMD_WR1);
        partner.read_reg(CMD_RD1, rd);
        check("unarmed write", rd, 16'h032b);
        // field edges: max scan, 13-bit, multiplier, both bands
        foreach (words[i]) begin
            partner.write_reg(CMD_WR1, words[i]);
            check_gain(words[i]);
            partner.read_reg(CMD_RD1, rd);
            check("cfg1 write", rd, words[i]);
        end
        // arming is spent by the first write
        partner.write_reg(CMD_WR1, 16'h0455);
        partner.send(16'h0aaa, CMD_WR1);
        partner.read_reg(CMD_RD1, rd);
        check("second write", rd, 16'h0455);
        partner.write_reg(CMD_WR2, 16'h040e);
        partner.read_reg(CMD_RD2, rd);
        check("cfg2 write", rd, 16'h040e);
        check_gain(16'h0455);
        partner.write_reg(CMD_WR2, 16'h0000);
        partner.read_reg(CMD_RD2, rd);
        check("cfg2 clear", rd, 16'h0000);
        partner.send(16'h0000, CMD_SRST);
        partner.read_reg(CMD_RD1, rd);
        check("cfg1 after soft reset", rd, 16'h0455);
        // two lines, multiplier on, 5 ns dim; fill both lines
        partner.write_reg(CMD_WR1, 16'h016b);
        partner.write_reg(CMD_WR2, 16'h0002);
        for (int n = 0; n < 32; n++) begin
            pix = (n == 0) ? 16'h0100 : 16'h0000;
            pix = (n == 17) ? 16'h0004 : pix;
            partner.send(pix, CMD_LATCH);
        end
        check("ready after fill", {15'h0000, data_ready}, 16'h0001);
        partner.send(16'h0000, CMD_VSYNC);
        check("sinks at slot start", sinks, 16'h0001);
        partner.gray(1);
        check("sinks after one step", sinks, 16'h0000);
        partner.gray(255);
        check("second line", {11'h000, scan_line}, 16'h0001);
        check("second line sinks", sinks, 16'h0002);
        partner.gray(256);
        check("first line again", {11'h000, scan_line}, 16'h0000);
        check("section two sinks", sinks, 16'h0001);
        partner.send(16'h0000, CMD_SRST);
        check("sinks after soft reset", sinks, 16'h0000);
        conclude();
    end

    // a full run is about 20000 clocks
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
